// ==== design/flash_defs.svh ====
// Purpose: constants of the flash program/erase control block
// Assumes: included by its bare name
// Notes:   byte addresses as the cpu sees them
`ifndef FLASH_DEFS_SVH
`define FLASH_DEFS_SVH

`define FLASH_MODE_ADDR      16'hFF80
`define FLASH_GAP_ADDR       16'hFF81
`define FLASH_LARGE_ADDR     16'hFF82
`define FLASH_SMALL_ADDR     16'hFF83
`define FLASH_REG_BASE       14'h3FE0

`define FLASH_MODE_RESET     8'h00
`define FLASH_LARGE_RESET    8'hF0
`define FLASH_SMALL_RESET    8'h00
`define FLASH_ABSENT_READ    8'hFF
`define FLASH_LARGE_RSVD     4'hF

`define FLASH_BIT_SUPPLY     7
`define FLASH_BIT_EV         3
`define FLASH_BIT_PV         2
`define FLASH_BIT_E          1
`define FLASH_BIT_P          0

`define FLASH_TOP_32K        16'h7FFF
`define FLASH_TOP_24K        16'h5FFF
`define FLASH_TOP_16K        16'h3FFF
`define FLASH_MASK_32K       4'hF
`define FLASH_MASK_24K       4'h7
`define FLASH_MASK_16K       4'h3

`define FLASH_SMALL_AREA_TOP 16'h0FFF
`define FLASH_LARGE0_TOP     16'h1FFF

`endif

// ==== design/flash_pkg.sv ====
// Purpose: types of the flash program/erase control block
// Assumes: used as flash_pkg::name, never imported
// Notes:   constants live in flash_defs.svh
package flash_pkg;

    typedef enum logic [2:0] {
        MODE_READ,
        MODE_PROGRAM,
        MODE_PROGRAM_VERIFY,
        MODE_ERASE,
        MODE_ERASE_VERIFY,
        MODE_PREWRITE_VERIFY
    } flash_mode_t;

    typedef enum logic {
        BUS_IDLE,
        BUS_SECOND
    } bus_state_t;

endpackage : flash_pkg

// ==== design/flash_block_decode.sv ====
// Purpose: tells whether an array address lies in a selected erase block
// Assumes: selects already masked for the size variant
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "flash_defs.svh"

module flash_block_decode (
    input  wire logic [15:0] addr,
    input  wire logic [3:0]  large_sel,
    input  wire logic [7:0]  small_sel,
    output logic             in_selected
);
    logic [2:0] small_idx;
    logic [1:0] large_idx;

    always_comb begin
        // 4 x 128 byte, one 512 byte, then 1 kbyte blocks
        if (addr[11:10] != 2'b00) begin
            // 1 kbyte blocks follow the 512 byte one: indices 5 to 7
            small_idx = 3'h4 + {1'b0, addr[11:10]};
        end else if (addr[9]) begin
            small_idx = 3'h4;
        end else begin
            small_idx = {1'b0, addr[8:7]};
        end
        // 4 kbyte block 0, then 8 kbyte blocks
        if (addr <= `FLASH_LARGE0_TOP) begin
            large_idx = 2'h0;
        end else begin
            large_idx = addr[14:13];
        end
        if (addr <= `FLASH_SMALL_AREA_TOP) begin
            in_selected = small_sel[small_idx];
        end else begin
            in_selected = large_sel[large_idx];
        end
    end

endmodule : flash_block_decode
`default_nettype wire

// ==== design/flash_array_port.sv ====
// Purpose: cpu side of the flash cell array, one word wide
// Assumes: array_rdata is valid in the cycle array_addr is presented
// Notes:   data is latched at the accept edge so the answer comes from a flop
`timescale 1ns/1ps
`default_nettype none

module flash_array_port (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        start,
    input  wire logic        wr,
    input  wire logic        prog_ok,
    input  wire logic [15:0] addr,
    input  wire logic [15:0] wdata,
    input  wire logic [15:0] array_rdata,
    output logic [14:0]      array_addr,
    output logic             array_re,
    output logic             array_we,
    output logic [15:0]      array_wdata,
    output logic [15:0]      rdata
);
    assign array_addr  = addr[15:1];
    assign array_re    = start && !wr;
    // only program mode into a selected block reaches the cells
    assign array_we    = start && wr && prog_ok;
    assign array_wdata = wdata;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 16'h0000;
        end else if (ce && array_re) begin
            rdata <= array_rdata;
        end
    end

endmodule : flash_array_port
`default_nettype wire

// ==== design/flash_program_erase_control.sv ====
// Purpose: flash mode control and erase block selection behind the cpu bus
// Assumes: one cpu access at a time; inputs synchronous to clk
// Notes:   every access takes two states: accept, then answer
//
// Function
// - array spans zero up to 7FFF, 5FFF or 3FFF by size variant.
// - array reads are 16 bits wide and finish in two states.
// - without 12 V, FF80-FF83 ignore writes and read FF.
// - mode control clears on reset, low power and missing 12 V.
// - with 12 V at reset, mode control reads 80.
// - mode bit 7 is read-only and shows the 12 V supply.
// - mode bit 3 enters or leaves erase-verify.
// - mode bit 2 enters or leaves program-verify.
// - mode bit 1 starts or ends erase on selected blocks.
// - mode bit 0 starts or ends program mode.
// - large-block select forces to F0 on reset, low power, no 12 V.
// - large-block bits 3..0 select their block when one.
// - large-block bits 7..4 read one and ignore writes.
// - missing large blocks of smaller variants have dead select bits.
// - five modes: program, both verifies, erase, prewrite-verify.
// - eight small-block bits; register clears like mode control.
// - large and small block address map as laid out.
`timescale 1ns/1ps
`default_nettype none
`include "flash_defs.svh"

module flash_program_erase_control #(
    parameter int SIZE_KB = 32
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic        prog_supply_pin,
    input  wire logic        low_power,
    input  wire logic        prewrite_req,
    input  wire logic        bus_req,
    input  wire logic        bus_we,
    input  wire logic        bus_word,
    input  wire logic [15:0] bus_addr,
    input  wire logic [15:0] bus_wdata,
    output logic             bus_ack,
    output logic [15:0]      bus_rdata,
    output logic [14:0]      array_addr,
    input  wire logic [15:0] array_rdata,
    output logic             array_re,
    output logic             array_we,
    output logic [15:0]      array_wdata,
    output flash_pkg::flash_mode_t flash_mode,
    output logic [3:0]       large_block_sel,
    output logic [7:0]       small_block_sel
);

    localparam logic [15:0] ARRAY_TOP =
        (SIZE_KB == 16) ? `FLASH_TOP_16K :
        (SIZE_KB == 24) ? `FLASH_TOP_24K : `FLASH_TOP_32K;
    localparam logic [3:0] LARGE_MASK =
        (SIZE_KB == 16) ? `FLASH_MASK_16K :
        (SIZE_KB == 24) ? `FLASH_MASK_24K : `FLASH_MASK_32K;

    flash_pkg::bus_state_t state;
    flash_pkg::bus_state_t next_state;

    logic [3:0]  mode_bits;
    logic [3:0]  large_bits;
    logic [7:0]  small_bits;
    logic        supply_ok;
    logic        force_clear;
    logic        accept;
    logic        reg_hit;
    logic        array_hit;
    logic        in_selected;
    logic        is_reg;
    logic        is_array;
    logic        use_array;
    logic [15:0] reg_rdata;
    logic [15:0] array_data;
    logic [15:0] next_reg_rdata;
    logic [15:0] odd_addr;
    logic        bus_word_q;
    logic        odd_q;

    assign supply_ok   = prog_supply_pin;
    // low power and a missing supply hold the registers at their reset values
    assign force_clear = low_power || !supply_ok;
    assign accept      = ce && bus_req && (state == flash_pkg::BUS_IDLE);
    assign odd_addr    = {bus_addr[15:1], 1'b1};

    function automatic logic in_regs(input logic [15:0] a);
        in_regs = (a[15:2] == `FLASH_REG_BASE);
    endfunction : in_regs

    function automatic logic in_array(input logic [15:0] a);
        in_array = (a <= ARRAY_TOP);
    endfunction : in_array

    // read view of one register byte
    function automatic logic [7:0] reg_byte(input logic [15:0] a);
        if (!supply_ok) begin
            reg_byte = `FLASH_ABSENT_READ;
        end else begin
            unique case (a)
                `FLASH_MODE_ADDR:
                    // supply flag live, so reset with 12 V reads 80
                    reg_byte = {supply_ok, 3'b000, mode_bits};
                `FLASH_LARGE_ADDR:
                    reg_byte = {`FLASH_LARGE_RSVD, large_bits};
                `FLASH_SMALL_ADDR:
                    reg_byte = small_bits;
                default:
                    reg_byte = `FLASH_ABSENT_READ;
            endcase
        end
    endfunction : reg_byte

    // does this write land on register byte r
    function automatic logic wr_hits(input logic [15:0] r);
        wr_hits = accept && bus_we && supply_ok &&
                  ((bus_addr == r) || (bus_word && odd_addr == r));
    endfunction : wr_hits

    // byte lane a written register takes; word writes put the even byte high
    function automatic logic [7:0] wr_byte(input logic [15:0] r);
        if (bus_word && r[0]) begin
            wr_byte = bus_wdata[7:0];
        end else if (bus_word) begin
            wr_byte = bus_wdata[15:8];
        end else begin
            wr_byte = bus_wdata[7:0];
        end
    endfunction : wr_byte

    assign reg_hit   = in_regs(bus_addr);
    assign array_hit = in_array(bus_addr);

    // bus sequencing: accept state, then answer state
    always_comb begin
        next_state = state;
        unique case (state)
            flash_pkg::BUS_IDLE:
                if (accept) begin
                    next_state = flash_pkg::BUS_SECOND;
                end
            flash_pkg::BUS_SECOND:
                next_state = flash_pkg::BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= flash_pkg::BUS_IDLE;
        end else if (ce) begin
            state <= next_state;
        end
    end

    assign bus_ack = ce && (state == flash_pkg::BUS_SECOND);

    // mode control; bits 6..4 have no storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_bits <= 4'(`FLASH_MODE_RESET);
        end else if (ce) begin
            if (force_clear) begin
                mode_bits <= 4'h0;
            end else if (wr_hits(`FLASH_MODE_ADDR)) begin
                mode_bits <= 4'(wr_byte(`FLASH_MODE_ADDR));
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            large_bits <= 4'(`FLASH_LARGE_RESET);
        end else if (ce) begin
            if (force_clear) begin
                large_bits <= 4'h0;
            end else if (wr_hits(`FLASH_LARGE_ADDR)) begin
                large_bits <= 4'(wr_byte(`FLASH_LARGE_ADDR));
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            small_bits <= `FLASH_SMALL_RESET;
        end else if (ce) begin
            if (force_clear) begin
                small_bits <= `FLASH_SMALL_RESET;
            end else if (wr_hits(`FLASH_SMALL_ADDR)) begin
                small_bits <= wr_byte(`FLASH_SMALL_ADDR);
            end
        end
    end

    // bits for blocks the variant lacks never reach the array
    assign large_block_sel = large_bits & LARGE_MASK;
    assign small_block_sel = small_bits;

    // two bits set at once is a software fault; erase is the safest winner
    // because it cannot corrupt a byte by programming it
    always_comb begin
        if (mode_bits[`FLASH_BIT_E]) begin
            flash_mode = flash_pkg::MODE_ERASE;
        end else if (mode_bits[`FLASH_BIT_P]) begin
            flash_mode = flash_pkg::MODE_PROGRAM;
        end else if (mode_bits[`FLASH_BIT_EV]) begin
            flash_mode = flash_pkg::MODE_ERASE_VERIFY;
        end else if (mode_bits[`FLASH_BIT_PV] && prewrite_req) begin
            flash_mode = flash_pkg::MODE_PREWRITE_VERIFY;
        end else if (mode_bits[`FLASH_BIT_PV]) begin
            flash_mode = flash_pkg::MODE_PROGRAM_VERIFY;
        end else begin
            flash_mode = flash_pkg::MODE_READ;
        end
    end

    flash_block_decode u_decode (
        .addr        (bus_addr),
        .large_sel   (large_block_sel),
        .small_sel   (small_block_sel),
        .in_selected (in_selected)
    );

    flash_array_port u_array (
        .clk         (clk),
        .rst_n       (rst_n),
        .ce          (ce),
        .start       (accept && array_hit),
        .wr          (bus_we),
        .prog_ok     (flash_mode == flash_pkg::MODE_PROGRAM && in_selected),
        .addr        (bus_addr),
        .wdata       (bus_wdata),
        .array_rdata (array_rdata),
        .array_addr  (array_addr),
        .array_re    (array_re),
        .array_we    (array_we),
        .array_wdata (array_wdata),
        .rdata       (array_data)
    );

    // register read data is latched at accept, like the array data
    always_comb begin
        if (bus_word) begin
            next_reg_rdata = {reg_byte(bus_addr), reg_byte(odd_addr)};
        end else begin
            next_reg_rdata = {reg_byte(bus_addr), reg_byte(bus_addr)};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
            is_reg    <= 1'b0;
            is_array  <= 1'b0;
            use_array <= 1'b0;
        end else if (accept) begin
            reg_rdata <= next_reg_rdata;
            is_reg    <= reg_hit;
            is_array  <= array_hit;
            use_array <= array_hit && !bus_we;
        end
    end

    // byte reads of the array give the addressed byte on both lanes
    always_comb begin
        if (use_array && !bus_word_q) begin
            bus_rdata = odd_q ? {2{array_data[7:0]}}
                              : {2{array_data[15:8]}};
        end else if (use_array) begin
            bus_rdata = array_data;
        end else if (is_reg) begin
            bus_rdata = reg_rdata;
        end else begin
            bus_rdata = 16'hFFFF;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_word_q <= 1'b0;
            odd_q      <= 1'b0;
        end else if (accept) begin
            bus_word_q <= bus_word;
            odd_q      <= bus_addr[0];
        end
    end

    property p_answer_two_states;
        @(posedge clk) disable iff (!rst_n)
        accept |=> (state == flash_pkg::BUS_SECOND);
    endproperty
    a_answer_two_states: assert property (p_answer_two_states)
        else $error("access not answered in its second state");

    property p_absent_reads_ff;
        @(posedge clk) disable iff (!rst_n)
        (accept && reg_hit && !supply_ok && !bus_we)
            |=> (bus_rdata == 16'hFFFF);
    endproperty
    a_absent_reads_ff: assert property (p_absent_reads_ff)
        else $error("register read without supply not all ones");

    property p_absent_no_write;
        @(posedge clk) disable iff (!rst_n)
        (!supply_ok && ce) |=> (mode_bits == 4'h0 && small_bits == 8'h00);
    endproperty
    a_absent_no_write: assert property (p_absent_no_write)
        else $error("registers not held clear without supply");

    property p_low_power_clear;
        @(posedge clk) disable iff (!rst_n)
        (low_power && ce) |=> (large_bits == 4'h0 &&
                               flash_mode == flash_pkg::MODE_READ);
    endproperty
    a_low_power_clear: assert property (p_low_power_clear)
        else $error("low power did not clear selection and mode");

    property p_supply_flag;
        @(posedge clk) disable iff (!rst_n)
        (accept && supply_ok && bus_addr == `FLASH_MODE_ADDR && !bus_we)
            |=> (bus_rdata[15:12] == 4'h8);
    endproperty
    a_supply_flag: assert property (p_supply_flag)
        else $error("mode read does not show supply flag");

    property p_erase_start;
        @(posedge clk) disable iff (!rst_n)
        (wr_hits(`FLASH_MODE_ADDR) && !low_power && !bus_word &&
         bus_wdata[7:0] == 8'h02)
            |=> (flash_mode == flash_pkg::MODE_ERASE) [*1] ##1 1'b1;
    endproperty
    a_erase_start: assert property (p_erase_start)
        else $error("erase bit write did not enter erase mode");

    property p_dead_block_bits;
        @(posedge clk) disable iff (!rst_n)
        (large_block_sel & ~LARGE_MASK) == 4'h0;
    endproperty
    a_dead_block_bits: assert property (p_dead_block_bits)
        else $error("select of missing large block is live");

    property p_reserved_ones;
        @(posedge clk) disable iff (!rst_n)
        (accept && bus_addr == `FLASH_LARGE_ADDR && !bus_we && !bus_word)
            |=> (bus_rdata[15:12] == 4'hF);
    endproperty
    a_reserved_ones: assert property (p_reserved_ones)
        else $error("reserved large-block bits do not read one");

    property p_array_range;
        @(posedge clk) disable iff (!rst_n)
        (array_re || array_we) |-> ({array_addr, 1'b1} <= ARRAY_TOP);
    endproperty
    a_array_range: assert property (p_array_range)
        else $error("array access beyond the variant top");

    property p_program_write;
        @(posedge clk) disable iff (!rst_n)
        array_we |-> (flash_mode == flash_pkg::MODE_PROGRAM && in_selected);
    endproperty
    a_program_write: assert property (p_program_write)
        else $error("array write outside program mode or block");

endmodule : flash_program_erase_control
`default_nettype wire

// ==== tb/tb_flash_program_erase_control.sv ====
// Purpose: self-checking bench for the flash program/erase control block
// Assumes: 24 kbyte variant, so the large block 3 select is dead
// Notes:   inputs move 1 ns after the rising edge, one access at a time
`timescale 1ns/1ps
`default_nettype none
`include "flash_defs.svh"

module tb_flash_program_erase_control;

    localparam int SIZE_KB = 24;

    logic                   clk;
    logic                   rst_n;
    logic                   ce;
    logic                   prog_supply_pin;
    logic                   low_power;
    logic                   prewrite_req;
    logic                   bus_req;
    logic                   bus_we;
    logic                   bus_word;
    logic [15:0]            bus_addr;
    logic [15:0]            bus_wdata;
    logic                   bus_ack;
    logic [15:0]            bus_rdata;
    logic [14:0]            array_addr;
    logic [15:0]            array_rdata;
    logic                   array_re;
    logic                   array_we;
    logic [15:0]            array_wdata;
    flash_pkg::flash_mode_t flash_mode;
    logic [3:0]             large_block_sel;
    logic [7:0]             small_block_sel;
    int                     failures;
    int                     num_checks;
    logic [15:0]            rd;
    logic                   seen_re;
    logic                   seen_we;

    // cell array stand-in: content follows the word address
    assign array_rdata = {1'b0, array_addr} ^ 16'hA5A5;

    flash_program_erase_control #(.SIZE_KB(SIZE_KB)) i_dut (
        .clk             (clk),
        .rst_n           (rst_n),
        .ce              (ce),
        .prog_supply_pin (prog_supply_pin),
        .low_power       (low_power),
        .prewrite_req    (prewrite_req),
        .bus_req         (bus_req),
        .bus_we          (bus_we),
        .bus_word        (bus_word),
        .bus_addr        (bus_addr),
        .bus_wdata       (bus_wdata),
        .bus_ack         (bus_ack),
        .bus_rdata       (bus_rdata),
        .array_addr      (array_addr),
        .array_rdata     (array_rdata),
        .array_re        (array_re),
        .array_we        (array_we),
        .array_wdata     (array_wdata),
        .flash_mode      (flash_mode),
        .large_block_sel (large_block_sel),
        .small_block_sel (small_block_sel)
    );

    always #5 clk = ~clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // request held through the answer cycle, where it is ignored
    task automatic access(input logic we, input logic word,
                          input logic [15:0] addr, input logic [15:0] wd);
        @(posedge clk);
        #1;
        bus_req   = 1'b1;
        bus_we    = we;
        bus_word  = word;
        bus_addr  = addr;
        bus_wdata = wd;
        #1;
        seen_re = array_re;
        seen_we = array_we;
        @(posedge clk);
        #1;
        check({15'h0, bus_ack}, 16'h0001);
        rd = bus_rdata;
        @(posedge clk);
        #1;
        bus_req = 1'b0;
        bus_we  = 1'b0;
    endtask : access

    task automatic wr8(input logic [15:0] addr, input logic [7:0] d);
        access(1'b1, 1'b0, addr, {8'h00, d});
    endtask : wr8

    task automatic rd8(input logic [15:0] addr, input logic [7:0] e);
        access(1'b0, 1'b0, addr, 16'h0000);
        check(rd, {e, e});
    endtask : rd8

    task automatic mode_is(input flash_pkg::flash_mode_t m);
        check({13'h0, flash_mode}, {13'h0, m});
    endtask : mode_is

    task automatic test_reset_values;
        rd8(`FLASH_MODE_ADDR, 8'h80);
        rd8(`FLASH_LARGE_ADDR, 8'hF0);
        rd8(`FLASH_SMALL_ADDR, 8'h00);
        rd8(`FLASH_GAP_ADDR, 8'hFF);
        mode_is(flash_pkg::MODE_READ);
        $display("test reset_values done");
    endtask : test_reset_values

    task automatic test_mode_bits;
        flash_pkg::flash_mode_t m [4];
        m = '{flash_pkg::MODE_PROGRAM, flash_pkg::MODE_ERASE,
              flash_pkg::MODE_PROGRAM_VERIFY, flash_pkg::MODE_ERASE_VERIFY};
        for (int i = 0; i < 4; i++) begin
            wr8(`FLASH_MODE_ADDR, 8'h70 | (8'h01 << i));
            mode_is(m[i]);
            rd8(`FLASH_MODE_ADDR, 8'h80 | (8'h01 << i));
            wr8(`FLASH_MODE_ADDR, 8'h00);
            mode_is(flash_pkg::MODE_READ);
        end
        prewrite_req = 1'b1;
        wr8(`FLASH_MODE_ADDR, 8'h04);
        mode_is(flash_pkg::MODE_PREWRITE_VERIFY);
        wr8(`FLASH_MODE_ADDR, 8'h00);
        prewrite_req = 1'b0;
        rd8(`FLASH_MODE_ADDR, 8'h80);
        $display("test mode_bits done");
    endtask : test_mode_bits

    task automatic test_block_select;
        wr8(`FLASH_LARGE_ADDR, 8'h0F);
        rd8(`FLASH_LARGE_ADDR, 8'hFF);
        check({12'h0, large_block_sel}, 16'h0007);
        wr8(`FLASH_LARGE_ADDR, 8'h05);
        check({12'h0, large_block_sel}, 16'h0005);
        wr8(`FLASH_SMALL_ADDR, 8'hA5);
        check({8'h0, small_block_sel}, 16'h00A5);
        rd8(`FLASH_SMALL_ADDR, 8'hA5);
        $display("test block_select done");
    endtask : test_block_select

    // a request held while ce is low must neither answer nor write
    task automatic test_clock_enable;
        @(posedge clk);
        #1;
        ce        = 1'b0;
        bus_req   = 1'b1;
        bus_we    = 1'b1;
        bus_word  = 1'b0;
        bus_addr  = `FLASH_SMALL_ADDR;
        bus_wdata = 16'h003C;
        repeat (3) @(posedge clk);
        #1;
        check({15'h0, bus_ack}, 16'h0000);
        check({8'h0, small_block_sel}, 16'h00A5);
        bus_req = 1'b0;
        bus_we  = 1'b0;
        ce      = 1'b1;
        rd8(`FLASH_SMALL_ADDR, 8'hA5);
        $display("test clock_enable done");
    endtask : test_clock_enable

    task automatic test_program_write;
        logic [15:0] a [4];
        logic        e [4];
        a = '{16'h0010, 16'h2000, 16'h0200, 16'h1000};
        e = '{1'b1, 1'b1, 1'b0, 1'b0};
        wr8(`FLASH_LARGE_ADDR, 8'h02);
        wr8(`FLASH_SMALL_ADDR, 8'h01);
        wr8(`FLASH_MODE_ADDR, 8'h01);
        for (int i = 0; i < 4; i++) begin
            access(1'b1, 1'b1, a[i], 16'h1234);
            check({15'h0, seen_we}, {15'h0, e[i]});
        end
        wr8(`FLASH_MODE_ADDR, 8'h00);
        access(1'b1, 1'b1, 16'h0010, 16'h1234);
        check({15'h0, seen_we}, 16'h0000);
        access(1'b0, 1'b1, 16'h5FFE, 16'h0000);
        check({15'h0, seen_re}, 16'h0001);
        check(rd, 16'h2FFF ^ 16'hA5A5);
        $display("test program_write done");
    endtask : test_program_write

    task automatic test_low_power;
        wr8(`FLASH_MODE_ADDR, 8'h02);
        wr8(`FLASH_LARGE_ADDR, 8'h0F);
        wr8(`FLASH_SMALL_ADDR, 8'hFF);
        low_power = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        low_power = 1'b0;
        mode_is(flash_pkg::MODE_READ);
        check({12'h0, large_block_sel}, 16'h0000);
        check({8'h0, small_block_sel}, 16'h0000);
        rd8(`FLASH_MODE_ADDR, 8'h80);
        rd8(`FLASH_LARGE_ADDR, 8'hF0);
        rd8(`FLASH_SMALL_ADDR, 8'h00);
        $display("test low_power done");
    endtask : test_low_power

    task automatic test_no_supply;
        wr8(`FLASH_SMALL_ADDR, 8'hAA);
        wr8(`FLASH_MODE_ADDR, 8'h08);
        prog_supply_pin = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        mode_is(flash_pkg::MODE_READ);
        check({8'h0, small_block_sel}, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            rd8(`FLASH_MODE_ADDR + 16'(i), 8'hFF);
        end
        wr8(`FLASH_SMALL_ADDR, 8'h55);
        wr8(`FLASH_MODE_ADDR, 8'h01);
        check({8'h0, small_block_sel}, 16'h0000);
        mode_is(flash_pkg::MODE_READ);
        prog_supply_pin = 1'b1;
        rd8(`FLASH_SMALL_ADDR, 8'h00);
        rd8(`FLASH_MODE_ADDR, 8'h80);
        $display("test no_supply done");
    endtask : test_no_supply

    task automatic test_mid_reset;
        wr8(`FLASH_MODE_ADDR, 8'h01);
        wr8(`FLASH_LARGE_ADDR, 8'h03);
        @(posedge clk);
        #1;
        rst_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        mode_is(flash_pkg::MODE_READ);
        check({12'h0, large_block_sel}, 16'h0000);
        rst_n = 1'b1;
        rd8(`FLASH_MODE_ADDR, 8'h80);
        rd8(`FLASH_LARGE_ADDR, 8'hF0);
        $display("test mid_reset done");
    endtask : test_mid_reset

    task automatic results;
        $display("checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : results

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        ce = 1'b1;
        prog_supply_pin = 1'b1;
        low_power = 1'b0;
        prewrite_req = 1'b0;
        bus_req = 1'b0;
        bus_we = 1'b0;
        bus_word = 1'b0;
        bus_addr = 16'h0000;
        bus_wdata = 16'h0000;
        failures = 0;
        num_checks = 0;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        test_reset_values();
        test_mode_bits();
        test_block_select();
        test_clock_enable();
        test_program_write();
        test_low_power();
        test_no_supply();
        test_mid_reset();
        results();
    end

    // whole run is under two hundred cycles; this is ample margin
    initial begin
        #50000;
        failures++;
        results();
    end

endmodule : tb_flash_program_erase_control
`default_nettype wire
